// ===== core/dtx_pkg.sv
/*
 * shared constants for the ds3 transmit payload nibble link:
 * frame geometry, nibble timing, register map and state types.
 * assumes one 100 mhz line clock drives both ends of the link.
 */
// ----------------------------------------------------------------
// How it works
// - transmit timing from line clock only
// - nibble clock divided down from line clock
// - latch nibble on third edge after rise
// - frame end high for last nibble period
// - terminal starts next frame after frame end
// - terminal updates nibble on nibble clock rise
// - terminal holds frame reference low
// - nibble mode: overhead indicator stays inactive
// - frame is 56 overhead bits, 84-bit runs
// - 1176 payload nibbles per frame
// - 1120 four-cycle, 56 five-cycle nibble periods
// - terminal drives nibble mode select high in nibble mode
// - timing select bit 1 set selects master
// - serial: terminal samples overhead indicator
// - indicator low: terminal advances serial bit
// - indicator high: terminal holds serial bit
// - gapped mode: indicator pulses payload bits
// ----------------------------------------------------------------
package dtx_pkg;

    // ------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------
    localparam int NIB_W = 4;
    localparam int FRAME_BITS = 4760;
    localparam int OH_BITS = 56;
    localparam int RUN_BITS = 84;
    localparam int FRAME_NIBS = 1176;
    localparam int SHORT_NIBS = 1120;
    localparam int PH_W = 3;
    localparam int BN_W = 5;
    localparam int BLK_W = 6;
    localparam logic [BN_W-1:0] BN_LAST = BN_W'(RUN_BITS / NIB_W - 1);
    localparam logic [BLK_W-1:0] BLK_LAST = BLK_W'(OH_BITS - 1);

    // ------------------------------------------------------------
    // nibble clock timing, in line clock cycles
    // ------------------------------------------------------------
    localparam logic [PH_W-1:0] SHORT_LEN = 3'h4;
    localparam logic [PH_W-1:0] LONG_LEN = 3'h5;
    localparam logic [PH_W-1:0] NCK_HIGH = 3'h2;
    localparam int CAPTURE_EDGE = 3;
    localparam logic [PH_W-1:0] CAP_PH = PH_W'(CAPTURE_EDGE - 1);

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADR_W = 16;
    localparam logic [ADR_W-1:0] MODE_ADDR = 16'h1100;
    localparam logic [ADR_W-1:0] STAT_ADDR = 16'h1104;
    localparam logic [ADR_W-1:0] CTRL_ADDR = 16'h1108;
    localparam logic [7:0] MODE_RESET = 8'h42;
    localparam int MODE_TREF_BIT = 1;
    localparam logic CTRL_RESET = 1'h0;
    localparam int CTRL_GAP_BIT = 0;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_NIB_BIT = 1;
    localparam int STAT_FCNT_LSB = 16;

    // ------------------------------------------------------------
    // terminal buffer
    // ------------------------------------------------------------
    localparam int BUF_DEPTH = 2;

    typedef enum logic {DTX_IDLE, DTX_RUN} dtx_state_t;

endpackage : dtx_pkg

// ===== core/dtx_link_if.sv
/*
 * pins between the framer transmit input and the terminal logic.
 * assumes both ends run on the same line clock.
 */
`timescale 1ns/1ns
interface dtx_link_if;
    logic nibble_clock_out;
    logic [dtx_pkg::NIB_W-1:0] nibble_data_in;
    logic frame_end_pulse;
    logic overhead_indicator;
    logic serial_payload_in;
    logic frame_reference_in;
    logic nibble_mode_select;

    modport dev
    (
        output nibble_clock_out,
        output frame_end_pulse,
        output overhead_indicator,
        input nibble_data_in,
        input serial_payload_in,
        input frame_reference_in,
        input nibble_mode_select
    );

    modport term
    (
        input nibble_clock_out,
        input frame_end_pulse,
        input overhead_indicator,
        output nibble_data_in,
        output serial_payload_in,
        output frame_reference_in,
        output nibble_mode_select
    );
endinterface : dtx_link_if

// ===== core/dtx_dev.sv
/*
 * framer end of the transmit payload link: frame master timing,
 * nibble clock, payload capture and a wishbone register slave.
 * assumes the line clock is clk and the terminal shares it.
 */
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module dtx_dev
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dtx_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link to terminal
    dtx_link_if.dev lnk,
    // captured payload
    output logic [dtx_pkg::NIB_W-1:0] pay_nibble,
    output logic pay_valid,
    output logic pay_last,
    output logic ser_bit,
    output logic ser_valid
);
    import dtx_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtx_state_t state, next_state;
    logic [PH_W-1:0] ph, next_ph;
    logic [BN_W-1:0] bn, next_bn;
    logic [BLK_W-1:0] blk, next_blk;
    logic [15:0] fcnt, next_fcnt;
    logic nck, next_nck;
    logic fend, next_fend;
    logic ohi, next_ohi;
    logic [NIB_W-1:0] next_pay_nibble;
    logic next_pay_valid, next_pay_last;
    logic next_ser_bit, next_ser_valid;
    logic [7:0] mode, next_mode;
    logic gap, next_gap;
    logic [31:0] next_dat;
    logic next_ack;
    logic nm_s1, nm_s2;
    logic run_req, run_n, nib_mode, cap_nib, cap_ser, hit;
    logic [PH_W-1:0] len;

    // overhead slot opens each 21-nibble block
    function automatic logic is_oh
    (
        input logic [BN_W-1:0] b,
        input logic [PH_W-1:0] p
    );
        return (b == '0) && (p == '0);
    endfunction : is_oh

    assign lnk.nibble_clock_out = nck;
    assign lnk.frame_end_pulse = fend;
    assign lnk.overhead_indicator = ohi;
    assign nib_mode = nm_s2;

    // ------------------------------------------------------------
    // frame timing and capture
    // ------------------------------------------------------------
    always_comb
    begin
        run_req = mode[MODE_TREF_BIT];
        len = (bn == '0) ? LONG_LEN : SHORT_LEN;
        next_state = state;
        next_ph = ph;
        next_bn = bn;
        next_blk = blk;
        next_fcnt = fcnt;
        case (state)
            DTX_IDLE:
            begin
                if (run_req)
                begin
                    next_state = DTX_RUN;
                end
            end
            DTX_RUN:
            begin
                if (!run_req)
                begin
                    next_state = DTX_IDLE;
                    next_ph = '0;
                    next_bn = '0;
                    next_blk = '0;
                end
                else if (ph != len - 3'h1)
                begin
                    next_ph = ph + 3'h1;
                end
                else
                begin
                    next_ph = '0;
                    if (bn != BN_LAST)
                    begin
                        next_bn = bn + 5'h01;
                    end
                    else
                    begin
                        next_bn = '0;
                        if (blk != BLK_LAST)
                        begin
                            next_blk = blk + 6'h01;
                        end
                        else
                        begin
                            next_blk = '0;
                            next_fcnt = fcnt + 16'h0001;
                        end
                    end
                end
            end
            default:
            begin
                next_state = DTX_IDLE;
            end
        endcase
        run_n = (next_state == DTX_RUN);
        next_nck = run_n && (next_ph < NCK_HIGH);
        next_fend = run_n && (next_blk == BLK_LAST)
            && (next_bn == BN_LAST);
        if (nib_mode)
        begin
            next_ohi = 1'b0;
        end
        else if (gap)
        begin
            next_ohi = run_n && !is_oh(next_bn, next_ph);
        end
        else
        begin
            next_ohi = run_n && is_oh(next_bn, next_ph);
        end
        cap_nib = (state == DTX_RUN) && nib_mode && (ph == CAP_PH);
        cap_ser = (state == DTX_RUN) && !nib_mode && !is_oh(bn, ph);
        next_pay_valid = cap_nib;
        next_pay_last = cap_nib && fend;
        next_pay_nibble = cap_nib ? lnk.nibble_data_in : pay_nibble;
        next_ser_valid = cap_ser;
        next_ser_bit = cap_ser ? lnk.serial_payload_in : ser_bit;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= DTX_IDLE;
            ph <= '0;
            bn <= '0;
            blk <= '0;
            fcnt <= '0;
            nck <= 1'b0;
            fend <= 1'b0;
            ohi <= 1'b0;
            pay_nibble <= '0;
            pay_valid <= 1'b0;
            pay_last <= 1'b0;
            ser_bit <= 1'b0;
            ser_valid <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            ph <= next_ph;
            bn <= next_bn;
            blk <= next_blk;
            fcnt <= next_fcnt;
            nck <= next_nck;
            fend <= next_fend;
            ohi <= next_ohi;
            pay_nibble <= next_pay_nibble;
            pay_valid <= next_pay_valid;
            pay_last <= next_pay_last;
            ser_bit <= next_ser_bit;
            ser_valid <= next_ser_valid;
        end
    end

    // ------------------------------------------------------------
    // mode strap synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nm_s1 <= 1'b0;
            nm_s2 <= 1'b0;
        end
        else if (ce)
        begin
            nm_s1 <= lnk.nibble_mode_select;
            nm_s2 <= nm_s1;
        end
    end

    // ------------------------------------------------------------
    // wishbone registers
    // ------------------------------------------------------------
    always_comb
    begin
        hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_ack = hit;
        next_dat = '0;
        next_mode = mode;
        next_gap = gap;
        if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0])
        begin
            case (wb_adr_i)
                MODE_ADDR: next_mode = wb_dat_i[7:0];
                CTRL_ADDR: next_gap = wb_dat_i[CTRL_GAP_BIT];
                default: next_mode = mode;
            endcase
        end
        if (hit && !wb_we_i)
        begin
            case (wb_adr_i)
                MODE_ADDR: next_dat[7:0] = mode;
                STAT_ADDR:
                begin
                    next_dat[STAT_RUN_BIT] = (state == DTX_RUN);
                    next_dat[STAT_NIB_BIT] = nib_mode;
                    next_dat[STAT_FCNT_LSB +: 16] = fcnt;
                end
                CTRL_ADDR: next_dat[CTRL_GAP_BIT] = gap;
                default: next_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode <= MODE_RESET;
            gap <= CTRL_RESET;
            wb_dat_o <= '0;
            wb_ack_o <= 1'b0;
        end
        else if (ce)
        begin
            mode <= next_mode;
            gap <= next_gap;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

endmodule : dtx_dev

// ===== core/dtx_term.sv
/*
 * terminal end of the transmit payload link: a two-entry buffer
 * feeding nibbles on the nibble clock or bits paced by the
 * overhead indicator. assumes the framer shares its clock.
 */
`timescale 1ns/1ns
module dtx_term
#(
    parameter int DEPTH = dtx_pkg::BUF_DEPTH
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // link to framer
    dtx_link_if.term lnk,
    // mode choice
    input wire logic use_nibble,
    input wire logic use_gapped,
    // payload source
    input wire logic [dtx_pkg::NIB_W-1:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    // status
    output logic frame_first,
    output logic underrun
);
    import dtx_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [2:0] BL_FULL = 3'(NIB_W);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NIB_W-1:0] mem [DEPTH];
    logic [PW-1:0] rp, wp, next_rp, next_wp;
    logic [CW-1:0] cnt, next_cnt;
    logic [NIB_W-1:0] nib, next_nib, sh, next_sh, head;
    logic [2:0] bl, next_bl;
    logic nck_d, armed, next_armed, nm, fref;
    logic next_ready, next_first, next_under;
    logic push, pop, rise, adv;

    assign lnk.nibble_data_in = nib;
    assign lnk.serial_payload_in = sh[NIB_W-1];
    assign lnk.nibble_mode_select = nm;
    assign lnk.frame_reference_in = fref;

    // ------------------------------------------------------------
    // buffer and pin pacing
    // ------------------------------------------------------------
    always_comb
    begin
        head = mem[rp];
        push = src_valid && src_ready;
        rise = lnk.nibble_clock_out && !nck_d;
        adv = !use_nibble && (lnk.overhead_indicator == use_gapped);
        pop = 1'b0;
        next_first = 1'b0;
        next_under = 1'b0;
        next_armed = armed;
        next_nib = nib;
        next_sh = sh;
        next_bl = bl;
        if (use_nibble)
        begin
            if (rise)
            begin
                next_armed = lnk.frame_end_pulse;
                next_first = armed;
                if (cnt != '0)
                begin
                    next_nib = head;
                    pop = 1'b1;
                end
                else
                begin
                    next_under = 1'b1;
                end
            end
        end
        else
        begin
            if (adv)
            begin
                if (bl != 3'h0)
                begin
                    next_sh = {sh[NIB_W-2:0], 1'b0};
                    next_bl = bl - 3'h1;
                end
                else
                begin
                    next_under = 1'b1;
                end
            end
            if ((next_bl == 3'h0) && (cnt != '0))
            begin
                next_sh = head;
                next_bl = BL_FULL;
                pop = 1'b1;
            end
        end
        next_rp = pop ? PW'(rp + 1'b1) : rp;
        next_wp = push ? PW'(wp + 1'b1) : wp;
        next_cnt = CW'(cnt + CW'(push) - CW'(pop));
        next_ready = (next_cnt < CW'(DEPTH));
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rp <= '0;
            wp <= '0;
            cnt <= '0;
            src_ready <= 1'b0;
            nib <= '0;
            sh <= '0;
            bl <= 3'h0;
            nck_d <= 1'b0;
            armed <= 1'b0;
            nm <= 1'b0;
            fref <= 1'b0;
            frame_first <= 1'b0;
            underrun <= 1'b0;
        end
        else if (ce)
        begin
            if (push)
            begin
                mem[wp] <= src_data;
            end
            rp <= next_rp;
            wp <= next_wp;
            cnt <= next_cnt;
            src_ready <= next_ready;
            nib <= next_nib;
            sh <= next_sh;
            bl <= next_bl;
            nck_d <= lnk.nibble_clock_out;
            armed <= next_armed;
            nm <= use_nibble;
            fref <= 1'b0;
            frame_first <= next_first;
            underrun <= next_under;
        end
    end

endmodule : dtx_term

// ===== dv/dtx_checker.sv
/*
 * pin checks for the dtx link: nibble clock shape, frame length,
 * frame end pulse, serial overhead pacing.
 * assumes the signals of one dtx_link_if and its line clock.
 */
`timescale 1ns/1ns
module dtx_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link pins
    input wire logic nibble_clock_out,
    input wire logic [dtx_pkg::NIB_W-1:0] nibble_data_in,
    input wire logic frame_end_pulse,
    input wire logic overhead_indicator,
    input wire logic serial_payload_in,
    input wire logic frame_reference_in,
    input wire logic nibble_mode_select,
    // serial pacing choice
    input wire logic use_gapped
);
    import dtx_pkg::*;
    // ------------------------------------------------------------
    // frame counters
    // ------------------------------------------------------------
    logic nck_d, fep_d, seen, next_seen;
    logic [12:0] fcyc, next_fcyc;
    logic [10:0] nrise, next_nrise;
    logic fep_rise;
    assign fep_rise = frame_end_pulse & ~fep_d;
    always_comb
    begin
        next_seen = seen;
        next_fcyc = fcyc + 13'h1;
        next_nrise = nrise + {10'h0, nibble_clock_out & ~nck_d};
        if (fep_rise)
        begin
            next_seen = 1'b1;
            next_fcyc = 13'h1;
            next_nrise = 11'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {nck_d, fep_d, seen} <= 3'h0;
            fcyc <= 13'h0;
            nrise <= 11'h0;
        end
        else
        begin
            {nck_d, fep_d, seen} <= {nibble_clock_out, frame_end_pulse,
                next_seen};
            fcyc <= next_fcyc;
            nrise <= next_nrise;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_nck_high_two: assert property ($rose(nibble_clock_out) |->
        nibble_clock_out[*2] ##1 !nibble_clock_out)
        else $error("nibble clock high time wrong");
    a_nck_low_len: assert property ($fell(nibble_clock_out) &&
        nibble_mode_select |-> !nibble_clock_out[*2] ##[1:2]
        $rose(nibble_clock_out)) else $error("nibble clock low time wrong");
    a_frame_cycles: assert property (fep_rise && seen &&
        nibble_mode_select |-> fcyc == 13'(FRAME_BITS))
        else $error("frame length in cycles wrong");
    a_frame_nibbles: assert property (fep_rise && seen &&
        nibble_mode_select |-> nrise == 11'(FRAME_NIBS))
        else $error("nibbles per frame wrong");
    a_fep_one_period: assert property ($rose(frame_end_pulse) |->
        $rose(nibble_clock_out) ##1
        (frame_end_pulse && !$rose(nibble_clock_out))[*3] ##1
        ((!frame_end_pulse && $rose(nibble_clock_out)) or
        (frame_end_pulse ##1 (!frame_end_pulse &&
        $rose(nibble_clock_out))))) else $error("frame end pulse width");
    a_oh_quiet: assert property (nibble_mode_select[*5] |->
        !overhead_indicator) else $error("indicator active in nibble mode");
    a_data_on_rise: assert property (nibble_mode_select &&
        $changed(nibble_data_in) |-> nibble_clock_out &&
        $past(nibble_clock_out) && !$past(nibble_clock_out, 2))
        else $error("nibble data moved off the clock rise");
    a_ref_low: assert property (!frame_reference_in)
        else $error("frame reference not low");
    a_oh_pacing: assert property (disable iff (!arst_n ||
        nibble_mode_select || use_gapped) $rose(overhead_indicator) |=>
        !overhead_indicator ##83 !overhead_indicator ##1
        $rose(overhead_indicator))
        else $error("overhead slot spacing wrong");
    a_gap_pacing: assert property (disable iff (!arst_n ||
        nibble_mode_select || !use_gapped) $fell(overhead_indicator) |=>
        overhead_indicator ##83 overhead_indicator ##1
        $fell(overhead_indicator))
        else $error("gapped clock spacing wrong");
    a_oh_hold: assert property ((overhead_indicator != use_gapped) &&
        !nibble_mode_select |=> $stable(serial_payload_in))
        else $error("serial bit moved in overhead slot");
    c_frame: cover property (fep_rise && seen);
    c_long: cover property ($rose(nibble_clock_out) ##5
        $rose(nibble_clock_out));
    c_serial: cover property ($rose(overhead_indicator));
    c_gapped: cover property ($fell(overhead_indicator) && use_gapped);
endmodule : dtx_checker

// ===== dv/tb.sv
/*
 * testbench joining framer and terminal: registers, nibble
 * stream, frame marks, serial pacing, buffer fill and drain.
 * assumes dtx_pkg, dtx_link_if, dtx_dev, dtx_term, dtx_checker.
 */
`timescale 1ns/1ns
module tb;
    import dtx_pkg::*;
    logic clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, use_nibble;
    logic [15:0] wb_adr;
    logic [3:0] wb_sel, src_data, pay_nibble, exp_nib;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic pay_valid, pay_last, ser_bit, ser_valid, src_valid, src_ready;
    logic frame_first, underrun, chk_on, started, use_gap, ser_pin;
    int errors = 0, total_checks = 0, cycles = 0, n;
    int npay = 0, nlast = 0, nfirst = 0, nunder = 0, nfull = 0;
    dtx_link_if lnk();
    dtx_dev dtx_dev_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .lnk(lnk),
        .pay_nibble(pay_nibble), .pay_valid(pay_valid),
        .pay_last(pay_last), .ser_bit(ser_bit), .ser_valid(ser_valid));
    dtx_term #(.DEPTH(BUF_DEPTH)) dtx_term_inst (.clk(clk),
        .arst_n(arst_n), .ce(1'b1), .lnk(lnk), .use_nibble(use_nibble),
        .use_gapped(use_gap), .src_data(src_data), .src_valid(src_valid),
        .src_ready(src_ready), .frame_first(frame_first),
        .underrun(underrun));
    dtx_checker dtx_checker_inst (.clk(clk), .arst_n(arst_n),
        .nibble_clock_out(lnk.nibble_clock_out),
        .nibble_data_in(lnk.nibble_data_in),
        .frame_end_pulse(lnk.frame_end_pulse),
        .overhead_indicator(lnk.overhead_indicator),
        .serial_payload_in(lnk.serial_payload_in),
        .frame_reference_in(lnk.frame_reference_in),
        .nibble_mode_select(lnk.nibble_mode_select),
        .use_gapped(use_gap));
    // ------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic wb_xfer(input logic we, input logic [15:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_wdat <= d;
        do
            @(posedge clk);
        while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
        chk_bit("ack drop", 1'b0, wb_ack);
    endtask : wb_xfer
    task automatic wb_write(input logic [15:0] a, input logic [3:0] s,
        input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, s, d, q);
    endtask : wb_write
    task automatic wb_read(input logic [15:0] a, output logic [31:0] q);
        wb_xfer(1'b0, a, 4'h0, 32'h0, q);
    endtask : wb_read
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // clock, source feed, stream monitor, timeout
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    always @(posedge clk)
    begin
        if (pay_valid === 1'b1 && chk_on)
        begin
            npay++;
            chk_bit("pay_last", npay % FRAME_NIBS == 0, pay_last);
            if (started || pay_nibble !== 4'h0)
            begin
                started = 1'b1;
                chk_word("pay_nibble", 32'(exp_nib), 32'(pay_nibble));
                exp_nib++;
            end
        end
        if (started && chk_on && underrun === 1'b1)
            nunder++;
        if (started && src_ready === 1'b0)
            nfull++;
        if (pay_last === 1'b1)
            nlast++;
        if (frame_first === 1'b1)
            nfirst++;
        if (ser_valid === 1'b1)
            chk_bit("ser_bit", ser_pin, ser_bit);
        ser_pin = lnk.serial_payload_in;
        if (arst_n && src_valid && src_ready === 1'b1)
            src_data <= src_data + 4'h1;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {arst_n, wb_cyc, wb_stb, wb_we, started, use_gap} = 6'h0;
        {wb_adr, wb_sel, wb_wdat} = 52'h0;
        {use_nibble, src_valid, chk_on} = 3'h7;
        src_data = 4'h1;
        exp_nib = 4'h1;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("nibble_mode_select", 1'b1, lnk.nibble_mode_select);
        wb_read(MODE_ADDR, rd);
        chk_word("mode reset", {24'h0, MODE_RESET}, rd);
        wb_read(STAT_ADDR, rd);
        chk_word("stat run nib", 32'h3, rd & 32'h3);
        wb_read(CTRL_ADDR, rd);
        chk_word("ctrl reset", 32'h0, rd);
        wb_read(16'h1200, rd);
        chk_word("unmapped", 32'h0, rd);
        wb_write(MODE_ADDR, 4'h1, 32'h3);
        wb_write(MODE_ADDR, 4'h0, 32'hff);
        wb_write(16'h1200, 4'h1, 32'hff);
        wb_write(STAT_ADDR, 4'h1, 32'h0);
        wb_read(MODE_ADDR, rd);
        chk_word("mode master", 32'h3, rd);
        wb_read(STAT_ADDR, rd);
        chk_word("stat kept", 32'h3, rd & 32'h3);
        wb_write(CTRL_ADDR, 4'h1, 32'h1);
        wb_read(CTRL_ADDR, rd);
        chk_word("ctrl", 32'h1, rd);
        wb_write(CTRL_ADDR, 4'h1, 32'h0);
        while (nlast < 2)
            @(posedge clk);
        repeat (20) @(posedge clk);
        chk_word("frame starts", nlast, nfirst);
        chk_word("underruns", 32'h0, nunder);
        chk_bit("buffer refused", 1'b1, nfull > 0);
        chk_on <= 1'b0;
        use_nibble <= 1'b0;
        repeat (60) @(posedge clk);
        n = 0;
        repeat (255)
        begin
            @(posedge clk);
            if (ser_valid === 1'b1)
                n++;
        end
        chk_word("serial bits", 32'd252, n);
        use_nibble <= 1'b1;
        wb_write(CTRL_ADDR, 4'h1, 32'h1);
        use_gap <= 1'b1;
        repeat (20) @(posedge clk);
        use_nibble <= 1'b0;
        repeat (60) @(posedge clk);
        n = 0;
        repeat (255)
        begin
            @(posedge clk);
            if (ser_valid === 1'b1)
                n++;
        end
        chk_word("gapped bits", 32'd252, n);
        src_valid <= 1'b0;
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            if (underrun === 1'b1)
                n++;
        end
        chk_bit("drained", 1'b1, n > 0);
        conclude();
    end
endmodule : tb
